// ==== tb/energy_accumulation_mode_control_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, want, got) begin checks_done++; if ((got) !== (want)) begin error_cnt++; \
	$display("ERROR %s exp %h got %h", nm, want, got); end end

module energy_accumulation_mode_control_tb;
	typedef struct packed {
		logic [7:0]  acc;
		logic [31:0] wb;
		logic [31:0] vb;
		logic [31:0] ab;
	} row_type;
	row_type          rows [5] = '{
		'{8'h00, 32'h0000_001e, 32'h0000_0006, 32'h0000_0014},
		'{8'h10, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000},
		'{8'h2c, 32'hffff_ffc4, 32'hffff_fff4, 32'h0000_0014},
		'{8'h34, 32'hffff_ffec, 32'hffff_fffc, 32'h0000_0014},
		'{8'h38, 32'hffff_ffec, 32'h0000_0004, 32'h0000_0014}};
	logic             pclk = 1'b0;
	logic             presetn = 1'b0;
	logic             psel = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite = 1'b0;
	logic [31:0]      paddr = 32'h0;
	logic [31:0]      pwdata = 32'h0;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic             irq;
	logic             sample_valid = 1'b0;
	logic [2:0]       zero_cross = 3'h0;
	logic [2:0][15:0] volt = {16'h0008, 16'h0006, 16'h0004};
	logic [2:0][15:0] curr = {16'h0002, 16'h000a, 16'h0002};
	logic [2:0][15:0] curr_shifted = {16'h0006, 16'h0002, 16'h0004};
	logic [2:0][15:0] volt_rms = {3{16'h000a}};
	logic [2:0][15:0] curr_rms = {3{16'h0004}};
	logic [2:0][31:0] fund_active = {3{32'h1}};
	logic [2:0][31:0] fund_reactive = {3{32'h1}};
	logic [31:0]      r;
	logic             e;
	logic [31:0]      ex [12];
	int               error_cnt = 0;
	int               checks_done = 0;
	int               cycles = 0;

	energy_accumulation_mode_control energy_accumulation_mode_control_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_valid(sample_valid), .volt(volt), .curr(curr), .curr_shifted(curr_shifted),
		.volt_rms(volt_rms), .curr_rms(curr_rms), .fund_active(fund_active),
		.fund_reactive(fund_reactive), .zero_cross(zero_cross), .irq(irq));

	always #50 pclk = ~pclk;

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			error_cnt++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		`CHK($sformatf("reg %h", a), x, r)
	endtask

	task automatic sample();
		sample_valid <= 1'b1;
		@(posedge pclk);
		sample_valid <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic zx(input logic [2:0] p);
		zero_cross <= p;
		@(posedge pclk);
		zero_cross <= 3'h0;
		@(posedge pclk);
	endtask

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_chk(32'h0003_9c04, 32'h0000_0000);
		rd_chk(32'h0003_9c08, 32'h0000_0078);
		rd_chk(32'h0003_9c44, 32'h0000_0000);
		rd_chk(32'h0003_9c48, 32'h0000_0064);
		apb(1'b1, 32'h0003_9c08, 32'h0000_00ff);
		rd_chk(32'h0003_9c08, 32'h0000_007f);
		apb(1'b1, 32'h0003_9c08, 32'h0000_0078);
		foreach (rows[i]) begin
			apb(1'b1, 32'h0003_9c04, {24'h0, rows[i].acc});
			sample();
			ex = '{32'h4, rows[i].wb, 32'h8, 32'h1, (rows[i].acc[5:4] == 2'h1) ? 32'h0 : 32'h1, 32'h1,
				32'h8, rows[i].vb, 32'h18, 32'h14, rows[i].ab, 32'h14};
			for (int n = 0; n < 12; n++)
				rd_chk(32'h0003_9000 + 32'(n * 4), ex[n]);
		end
		rd_chk(32'h0003_9c40, 32'h0000_0880);
		apb(1'b1, 32'h0003_9c44, 32'h0000_0080);
		@(posedge pclk);
		`CHK("irq", 1'b1, irq)
		apb(1'b1, 32'h0003_9c44, 32'h0000_0000);
		@(posedge pclk);
		`CHK("irq", 1'b0, irq)
		apb(1'b1, 32'h0003_9c40, 32'h0000_0080);
		rd_chk(32'h0003_9c40, 32'h0000_0800);
		apb(1'b1, 32'h0003_9c40, 32'hffff_ffff);
		// Phase B flips under either source, so bits 6 and 12 are the ones that show the fundamental source.
		apb(1'b1, 32'h0003_9c04, 32'h0000_00c0);
		fund_active <= {32'h1, 32'h1, 32'hffff_fffb};
		fund_reactive <= {32'hffff_fffb, 32'h1, 32'h1};
		sample();
		rd_chk(32'h0003_9c40, 32'h0000_18c0);
		apb(1'b1, 32'h0003_9c40, 32'hffff_ffff);
		apb(1'b0, 32'h0003_9000, 32'h0);
		apb(1'b0, 32'h0003_9018, 32'h0);
		apb(1'b1, 32'h0003_9c48, 32'h0000_0002);
		apb(1'b1, 32'h0003_9c08, 32'h0000_000f);
		repeat (3) sample();
		rd_chk(32'h0003_9018, 32'h0000_0000);
		rd_chk(32'h0003_9024, 32'h0000_0014);
		rd_chk(32'h0003_9000, 32'h0000_0000);
		zx(3'h2);
		zx(3'h1);
		rd_chk(32'h0003_9000, 32'h0000_0000);
		zx(3'h1);
		rd_chk(32'h0003_9000, 32'h0000_000c);
		rd_chk(32'h0003_9018, 32'h0000_0018);
		rd_chk(32'h0003_9018, 32'h0000_0018);
		rd_chk(32'h0003_9024, 32'h0000_003c);
		rd_chk(32'h0003_9c40, 32'h0001_0000);
		apb(1'b0, 32'h0000_0100, 32'h0);
		`CHK("unmapped err", 1'b1, e)
		`CHK("unmapped data", 32'h0, r)
		apb(1'b0, 32'h0003_9c05, 32'h0);
		`CHK("misaligned err", 1'b1, e)
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_chk(32'h0003_9c08, 32'h0000_0078);
		rd_chk(32'h0003_9c04, 32'h0000_0000);
		summarize();
	end
endmodule

`default_nettype wire

// ==== tb/energy_mode_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "energy_mode_defines.svh"

module energy_mode_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq
);
	logic [7:0] acc_shadow;
	logic [7:0] lc_shadow;
	wire logic  access = psel && penable;

	// Shadows of the mode registers let readback be judged against every write seen on the bus.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_shadow <= `ACCUM_MODE_RESET;
			lc_shadow <= `LINE_CYCLE_MODE_RESET;
		end else if (access && pwrite) begin
			if (paddr == 32'h0003_9c04)
				acc_shadow <= pwdata[7:0];
			if (paddr == 32'h0003_9c08)
				lc_shadow <= pwdata[7:0] & `LC_WRITABLE_MASK;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence read_of(a);
		access && !pwrite && paddr == a;
	endsequence
	sequence mask_cleared;
		access && pwrite && paddr == 32'h0003_9c44 && pwdata == 32'h0;
	endsequence

	a_ready_high: assert property (pready) else $error("pready low");
	a_slverr_idle: assert property (!psel |-> !pslverr) else $error("pslverr without select");
	a_misalign_err: assert property (access && !pwrite && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
		else $error("misaligned read accepted");
	a_acc_readback: assert property (read_of(32'h0003_9c04) |-> prdata == {24'h0, acc_shadow} && !pslverr)
		else $error("accumulation mode readback wrong");
	a_lc_readback: assert property (read_of(32'h0003_9c08) |-> prdata == {24'h0, lc_shadow})
		else $error("line cycle mode readback wrong");
	a_status_used: assert property (read_of(32'h0003_9c40) |-> (prdata & ~`STATUS_USED_MASK) == 32'h0)
		else $error("status has unused bits");
	a_mask_quiet: assert property (mask_cleared |-> ##2 !irq) else $error("irq with zero mask");
	a_reset_irq_low: assert property ($rose(presetn) |-> !irq [*3]) else $error("irq after reset");
endmodule

bind energy_accumulation_mode_control energy_mode_asserts energy_mode_asserts_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

`default_nettype wire

// ==== verilog/energy_accumulation_mode_control.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "energy_mode_defines.svh"

//Function
//- Reserved reactive mode 11 acts like 00
//- Connection select bits 5:4 choose products
//- Select 00: each phase uses own products
//- Select 01: phase B energies get zero
//- Select 10: phase B voltage is -(A+C)
//- Select 11: phase B voltage is -A
//- Phases A and C always use own products
//- Active source 0: total power sets 6-8
//- Active source 1: fundamental power sets 6-8
//- Reactive source 0: total power sets 10-12
//- Reactive source 1: fundamental sets 10-12
//- Bit 0 puts watt-hours into line-cycle
//- Bit 1 puts var-hours into line-cycle
//- Bit 2 puts VA-hours into line-cycle
//- Bits 3-5 select counted phase crossings
//- Bit 6 set: reading energy zeroes it
//- Bit 7 reserved, reads zero, no effect
module energy_accumulation_mode_control (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [31:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic                     sample_valid,
	input  wire logic [2:0][15:0]         volt,
	input  wire logic [2:0][15:0]         curr,
	input  wire logic [2:0][15:0]         curr_shifted,
	input  wire logic [2:0][15:0]         volt_rms,
	input  wire logic [2:0][15:0]         curr_rms,
	input  wire logic [2:0][31:0]         fund_active,
	input  wire logic [2:0][31:0]         fund_reactive,
	input  wire logic [2:0]               zero_cross,
	output logic                          irq
);

	logic [7:0]                           accumulation_mode_config;
	logic [7:0]                           line_cycle_mode_config;
	logic [31:0]                          primary_status_reg;
	logic [31:0]                          interrupt_mask;
	logic [15:0]                          line_cycle_length;
	logic [31:0]                          energy [`ENERGY_COUNT];
	logic [31:0]                          integ [`ENERGY_COUNT];
	logic signed [31:0]                   addend [`ENERGY_COUNT];
	logic signed [16:0]                   volt_eff [3];
	logic signed [32:0]                   prod_active [3];
	logic signed [32:0]                   prod_reactive [3];
	logic [2:0]                           act_sign;
	logic [2:0]                           react_sign;
	logic [2:0]                           act_src_sign;
	logic [2:0]                           react_src_sign;
	logic [31:0]                          status_set;
	logic [31:0]                          next_status;
	logic [15:0]                          crossing_count;
	logic [15:0]                          crossing_total;
	logic [1:0]                           crossing_hits;
	logic                                 line_cycle_end;
	logic                                 any_line_cycle;
	logic [31:0]                          next_rdata;
	logic                                 next_slverr;
	logic                                 read_access;
	logic                                 write_access;
	energy_mode_pkg::wiring_type          wiring_connection_select;
	energy_mode_pkg::reactive_mode_type   reactive_accum_mode;
	logic                                 active_reversal_source_sel;
	logic                                 reactive_reversal_source_sel;
	logic                                 active_energy_cycle_mode;
	logic                                 reactive_energy_cycle_mode;
	logic                                 apparent_energy_cycle_mode;
	logic [2:0]                           crossing_phase_select;
	logic                                 clear_on_read_enable;

	// Returns the word index when the byte address is word aligned with bits 31:18 clear, otherwise an index nothing decodes.
	function automatic logic [15:0] word_index(input logic [31:0] addr);
		if (addr[1:0] != 2'h0 || addr[31:18] != 14'h0000) begin
			return 16'h0000;
		end
		return addr[17:2];
	endfunction

	// Flags which energy accumulator, if any, an address selects.
	function automatic logic energy_hit(input logic [31:0] addr, input int unsigned n);
		return word_index(addr) == 16'(`ENERGY_BASE_INDEX + n);
	endfunction

	assign wiring_connection_select     = energy_mode_pkg::wiring_type'(accumulation_mode_config[`ACCUM_CONSEL_LSB +: 2]);
	assign reactive_accum_mode          = energy_mode_pkg::reactive_mode_type'(accumulation_mode_config[`ACCUM_VAR_MODE_LSB +: 2]);
	assign active_reversal_source_sel   = accumulation_mode_config[`ACCUM_ACT_REV_BIT];
	assign reactive_reversal_source_sel = accumulation_mode_config[`ACCUM_REACT_REV_BIT];
	assign active_energy_cycle_mode     = line_cycle_mode_config[`LC_ACTIVE_BIT];
	assign reactive_energy_cycle_mode   = line_cycle_mode_config[`LC_REACTIVE_BIT];
	assign apparent_energy_cycle_mode   = line_cycle_mode_config[`LC_APPARENT_BIT];
	assign crossing_phase_select        = line_cycle_mode_config[`LC_CROSS_SEL_LSB +: 3];
	assign clear_on_read_enable         = line_cycle_mode_config[`LC_CLEAR_ON_READ_BIT];

	assign read_access  = psel && penable && !pwrite;
	assign write_access = psel && penable && pwrite;
	// Every register answers at once, so the access phase never needs a wait state.
	assign pready       = 1'b1;

	// Phase B voltage as seen by the energy products.
	always_comb begin
		volt_eff[0] = 17'(signed'(volt[0]));
		volt_eff[2] = 17'(signed'(volt[2]));
		unique case (wiring_connection_select)
			energy_mode_pkg::wye_two_sensor: begin
				volt_eff[1] = -17'(signed'(volt[0])) - 17'(signed'(volt[2]));
			end
			energy_mode_pkg::delta_four_wire: begin
				volt_eff[1] = -17'(signed'(volt[0]));
			end
			default: begin
				volt_eff[1] = 17'(signed'(volt[1]));
			end
		endcase
	end

	// Products are halved so a full-scale product fits the 32-bit accumulators.
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			prod_active[p]   = volt_eff[p] * 33'(signed'(curr[p]));
			prod_reactive[p] = volt_eff[p] * 33'(signed'(curr_shifted[p]));
			addend[p]        = prod_active[p][32:1];
			addend[3 + p]    = signed'(fund_active[p]);
			// Mode 10 follows the active sign; reserved codes fall back to signed.
			if (reactive_accum_mode == energy_mode_pkg::var_by_active && prod_active[p][32]) begin
				addend[6 + p] = -prod_reactive[p][32:1];
			end else begin
				addend[6 + p] = prod_reactive[p][32:1];
			end
			addend[9 + p]    = signed'({1'b0, 31'(32'(volt_rms[p] * curr_rms[p]) >> 1)});
		end
		// Phase B has no voltage sensor in this wiring, so none of its energies may move.
		if (wiring_connection_select == energy_mode_pkg::delta_three_wire) begin
			addend[1]  = 32'sh0000_0000;
			addend[4]  = 32'sh0000_0000;
			addend[7]  = 32'sh0000_0000;
			addend[10] = 32'sh0000_0000;
		end
	end

	always_comb begin
		crossing_hits = 2'(zero_cross[0] & crossing_phase_select[0])
			+ 2'(zero_cross[1] & crossing_phase_select[1])
			+ 2'(zero_cross[2] & crossing_phase_select[2]);
		any_line_cycle = active_energy_cycle_mode || reactive_energy_cycle_mode || apparent_energy_cycle_mode;
		crossing_total = crossing_count + 16'(crossing_hits);
		// The interval closes only on a counted crossing, so a length of zero ends at the first one.
		line_cycle_end = any_line_cycle && crossing_total >= line_cycle_length && crossing_hits != 2'h0;
	end

	// Several selected phases add several crossings per period, shortening the interval.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crossing_count <= 16'h0000;
		end else if (!any_line_cycle || line_cycle_end) begin
			crossing_count <= 16'h0000;
		end else begin
			crossing_count <= crossing_total;
		end
	end

	// Each accumulator family follows its own line-cycle mode bit.
	generate
		for (genvar n = 0; n < `ENERGY_COUNT; n++) begin : gen_energy
			logic cycle_mode;
			logic cleared;
			logic [31:0] inc;

			assign cycle_mode = (n < 6) ? active_energy_cycle_mode
				: (n < 9) ? reactive_energy_cycle_mode
				: apparent_energy_cycle_mode;
			assign cleared = read_access && clear_on_read_enable && energy_hit(paddr, n);
			assign inc     = sample_valid ? unsigned'(addend[n]) : 32'h0000_0000;

			// Outside line-cycle mode only the value handed out in the setup cycle is removed, so samples that land
			// between setup and access, or with the access itself, are kept rather than lost.
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					energy[n] <= 32'h0000_0000;
				end else if (cycle_mode) begin
					if (line_cycle_end) begin
						energy[n] <= integ[n] + inc;
					end else if (cleared) begin
						energy[n] <= 32'h0000_0000;
					end
				end else if (cleared) begin
					energy[n] <= energy[n] - prdata + inc;
				end else begin
					energy[n] <= energy[n] + inc;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					integ[n] <= 32'h0000_0000;
				end else if (!cycle_mode || line_cycle_end) begin
					integ[n] <= 32'h0000_0000;
				end else begin
					integ[n] <= integ[n] + inc;
				end
			end
		end
	endgenerate

	// Reversal detection compares each new sign with the one last seen.
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			act_src_sign[p]   = active_reversal_source_sel ? fund_active[p][31] : prod_active[p][32];
			react_src_sign[p] = reactive_reversal_source_sel ? fund_reactive[p][31]
				: prod_reactive[p][32];
		end
		status_set = 32'h0000_0000;
		if (sample_valid) begin
			status_set[`ST_ACT_REV_LSB +: 3]   = act_src_sign ^ act_sign;
			status_set[`ST_REACT_REV_LSB +: 3] = react_src_sign ^ react_sign;
		end
		status_set[`ST_LC_DONE_BIT] = line_cycle_end;
	end

	// Signs start positive after reset, so a first negative sample counts as a reversal.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_sign   <= 3'h0;
			react_sign <= 3'h0;
		end else if (sample_valid) begin
			act_sign   <= act_src_sign;
			react_sign <= react_src_sign;
		end
	end

	// A new event wins over a write-one-to-clear in the same cycle.
	always_comb begin
		next_status = primary_status_reg | status_set;
		if (write_access && word_index(paddr) == `STATUS_INDEX) begin
			next_status = (primary_status_reg & ~pwdata) | status_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			primary_status_reg <= 32'h0000_0000;
		end else begin
			primary_status_reg <= next_status;
		end
	end

	// The line follows the status it will show, so it rises with the flag, not a clock later;
	// a mask write takes effect one clock after it lands.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_status & interrupt_mask);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accumulation_mode_config <= `ACCUM_MODE_RESET;
			line_cycle_mode_config   <= `LINE_CYCLE_MODE_RESET;
			interrupt_mask           <= 32'h0000_0000;
			line_cycle_length        <= `LINE_CYCLE_LEN_RESET;
		end else if (write_access) begin
			// Bits with no function are dropped here, except accumulation mode bits 1:0, which are stored and read back.
			unique case (word_index(paddr))
				`ACCUM_MODE_INDEX: begin
					accumulation_mode_config <= pwdata[7:0];
				end
				`LINE_CYCLE_MODE_INDEX: begin
					line_cycle_mode_config <= pwdata[7:0] & `LC_WRITABLE_MASK;
				end
				`MASK_INDEX: begin
					interrupt_mask <= pwdata & `STATUS_USED_MASK;
				end
				`LINE_CYCLE_LEN_INDEX: begin
					line_cycle_length <= pwdata[15:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Read data is fetched in the setup cycle so the access phase completes with no wait state.
	always_comb begin
		next_rdata  = 32'h0000_0000;
		next_slverr = 1'b0;
		unique case (word_index(paddr))
			`ACCUM_MODE_INDEX: begin
				next_rdata = {24'h000000, accumulation_mode_config};
			end
			`LINE_CYCLE_MODE_INDEX: begin
				next_rdata = {24'h000000, line_cycle_mode_config};
			end
			`STATUS_INDEX: begin
				next_rdata = primary_status_reg;
			end
			`MASK_INDEX: begin
				next_rdata = interrupt_mask;
			end
			`LINE_CYCLE_LEN_INDEX: begin
				next_rdata = {16'h0000, line_cycle_length};
			end
			default: begin
				next_slverr = 1'b1;
				for (int n = 0; n < `ENERGY_COUNT; n++) begin
					if (energy_hit(paddr, n)) begin
						next_rdata  = energy[n];
						next_slverr = 1'b0;
					end
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
			pslverr <= next_slverr;
		end else if (penable || !psel) begin
			// The error answer stands for the access phase only and is gone once it completes.
			pslverr <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ==== verilog/energy_mode_defines.svh ====
`ifndef ENERGY_MODE_DEFINES_SVH
`define ENERGY_MODE_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define ACCUM_MODE_INDEX      16'he701
`define LINE_CYCLE_MODE_INDEX 16'he702
`define STATUS_INDEX          16'he710
`define MASK_INDEX            16'he711
`define LINE_CYCLE_LEN_INDEX  16'he712
`define ENERGY_BASE_INDEX     16'he400
`define ENERGY_COUNT          12

// Accumulation mode fields.
`define ACCUM_VAR_MODE_LSB    2
`define ACCUM_CONSEL_LSB      4
`define ACCUM_ACT_REV_BIT     6
`define ACCUM_REACT_REV_BIT   7
`define ACCUM_MODE_RESET      8'h00

// Line-cycle mode fields.
`define LC_ACTIVE_BIT         0
`define LC_REACTIVE_BIT       1
`define LC_APPARENT_BIT       2
`define LC_CROSS_SEL_LSB      3
`define LC_CLEAR_ON_READ_BIT  6
`define LC_WRITABLE_MASK      8'h7f
`define LINE_CYCLE_MODE_RESET 8'h78

// Status fields and line-cycle length reset.
`define ST_ACT_REV_LSB        6
`define ST_REACT_REV_LSB      10
`define ST_LC_DONE_BIT        16
`define STATUS_USED_MASK      32'h0001_1dc0
`define LINE_CYCLE_LEN_RESET  16'h0064

`endif

// ==== verilog/energy_mode_pkg.sv ====
`default_nettype none
package energy_mode_pkg;

	typedef enum logic [1:0] {
		wye_three_sensor = 2'h0,
		delta_three_wire = 2'h1,
		wye_two_sensor   = 2'h2,
		delta_four_wire  = 2'h3
	} wiring_type;

	typedef enum logic [1:0] {
		var_signed     = 2'h0,
		var_reserved_a = 2'h1,
		var_by_active  = 2'h2,
		var_reserved_b = 2'h3
	} reactive_mode_type;

endpackage

`default_nettype wire
